// ===== sac_defs.svh
// timing and field constants for the converter sequencer
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
`define SAC_PERIODS 4'hd
`define SAC_PER_FIRST 4'h1
`define SAC_PER_TWO 4'h2
`define SAC_PER_TRACK_END 4'h3
`define SAC_PER_MSB 4'h4
`define SAC_PER_LAST 4'hd
`define SAC_RES_BITS 10
`define SAC_UPPER_LO 2
`define SAC_UPPER_HI 9
`define SAC_LOWER_HI 1
`define SAC_RESULT_RST 10'h000
`define SAC_SAR_MSB 10'h200
`define SAC_INT_DIV 8'h0c
`endif

// ===== sac_pkg.sv
// types shared by the converter sequencer
package sac_pkg;
	typedef enum logic [2:0] {
		SAC_RUN = 3'h1,
		SAC_WAIT_P2 = 3'h2,
		SAC_STOPPED = 3'h4
	} sac_state_t;
	typedef struct packed {
		logic [9:0] data;
		logic [9:0] data_oe;
	} sac_bus_t;
endpackage

// ===== sac_ctrl.sv
// successive-approximation conversion sequencer with latched three-state result
`timescale 1ns/1ps
// Summary of operation
// - start held low: free-run, 13 periods each
// - track input during periods 1 to 3
// - result updates only at start of next period 1
// - ready rises at start of period 1, drops period 2
// - ready-clear input low clears ready asynchronously
// - upper enable D2-D9, lower enable D0-D1
// - internal clock stops in period 2 without start
// - start pulse clears ready then restarts clock
// - period 2 may stretch by stopped time
// - external clock: remain in period 2
// - external: start drops ready, next edge period 3
// - ready drops at later of period 2, start
// - hold sampled input periods 4 through 13
// - result is 10-bit unsigned straight binary
// - msb decided period 4, lsb period 13
// - start recognised only after period 13 ends
// - sequencing advances on rising clock edge
`include "sac_defs.svh"
module sac_ctrl #(
	parameter logic [7:0] INT_DIV = `SAC_INT_DIV
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// mode: high selects the internal period clock
	input wire logic use_internal_clock,
	// external conversion clock pin
	input wire logic ext_conv_clock,
	// control pins, active low
	input wire logic conversion_start_n,
	input wire logic ready_flag_clear_n,
	input wire logic upper_bits_output_enable_n,
	input wire logic lower_bits_output_enable_n,
	// comparator decision for the bit under test
	input wire logic comparator_high,
	// analog switch controls
	output logic track_input,
	output logic hold_input,
	output logic [9:0] trial_code,
	// result bus, ready flag and internal clock running status
	output sac_pkg::sac_bus_t result_bus,
	output logic result_ready_flag,
	output logic internal_clock_running
);
	logic [2:0] start_sync_r;
	logic [2:0] eclk_sync_r;
	logic [2:0] clr_sync_r;
	logic start_low;
	logic eclk_rise;
	logic clr_low;
	logic [7:0] div_cnt_r;
	logic tick;
	logic [3:0] period_r;
	logic [3:0] period_nxt;
	sac_pkg::sac_state_t state_r;
	logic [9:0] sar_r;
	logic [9:0] bit_r;
	logic [9:0] result_r;
	logic ready_r;
	logic new_period1;

	// three-stage pin synchronisers; for start and clear, stage two and three must agree
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			start_sync_r <= 3'h7;
			eclk_sync_r <= 3'h0;
			clr_sync_r <= 3'h7;
		end
		else
		begin
			start_sync_r <= {start_sync_r[1:0], conversion_start_n};
			eclk_sync_r <= {eclk_sync_r[1:0], ext_conv_clock};
			clr_sync_r <= {clr_sync_r[1:0], ready_flag_clear_n};
		end
	end
	assign start_low = !start_sync_r[1] && !start_sync_r[2];
	assign clr_low = !clr_sync_r[1] && !clr_sync_r[2];
	assign eclk_rise = eclk_sync_r[1] && !eclk_sync_r[2];

	// internal period divider; held at zero while stopped so period 2 stretches
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			div_cnt_r <= 8'h00;
		else if (!use_internal_clock || state_r == sac_pkg::SAC_STOPPED)
			div_cnt_r <= 8'h00;
		else if (div_cnt_r == INT_DIV - 8'h01)
			div_cnt_r <= 8'h00;
		else
			div_cnt_r <= div_cnt_r + 8'h01;
	end

	always_comb
	begin
		if (use_internal_clock)
			tick = (div_cnt_r == INT_DIV - 8'h01) && state_r != sac_pkg::SAC_STOPPED;
		else
			tick = eclk_rise;
	end

	always_comb
	begin
		if (period_r == `SAC_PERIODS)
			period_nxt = `SAC_PER_FIRST;
		else
			period_nxt = period_r + 4'h1;
	end

	assign new_period1 = tick && period_r == `SAC_PER_LAST;

	// period counter and start handling
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			period_r <= `SAC_PER_FIRST;
			state_r <= sac_pkg::SAC_RUN;
		end
		else
		begin
			case (state_r)
				sac_pkg::SAC_RUN:
				begin
					// start sampled only in period 1
					if (tick && period_r == `SAC_PER_FIRST && !start_low)
						state_r <= sac_pkg::SAC_WAIT_P2;
					if (tick)
						period_r <= period_nxt;
				end
				sac_pkg::SAC_WAIT_P2:
				begin
					// internal clock stops in period 2
					if (start_low)
					begin
						state_r <= sac_pkg::SAC_RUN;
					end
					else if (use_internal_clock)
						state_r <= sac_pkg::SAC_STOPPED;
				end
				sac_pkg::SAC_STOPPED:
				begin
					if (start_low)
						state_r <= sac_pkg::SAC_RUN;
					// external clock keeps cycling in period 2
					else if (!use_internal_clock)
						state_r <= sac_pkg::SAC_WAIT_P2;
				end
				default:
					state_r <= sac_pkg::SAC_RUN;
			endcase
		end
	end

	// successive approximation, msb in period 4
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sar_r <= `SAC_RESULT_RST;
			bit_r <= `SAC_SAR_MSB;
		end
		else if (tick && state_r == sac_pkg::SAC_RUN)
		begin
			if (period_r == `SAC_PER_TRACK_END)
			begin
				sar_r <= `SAC_SAR_MSB;
				bit_r <= `SAC_SAR_MSB;
			end
			else if (period_r >= `SAC_PER_MSB)
			begin
				// straight binary, keep bit when input at or above trial
				sar_r <= (comparator_high ? sar_r : (sar_r & ~bit_r)) | (bit_r >> 1);
				bit_r <= bit_r >> 1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			result_r <= `SAC_RESULT_RST;
		else if (new_period1)
			result_r <= comparator_high ? sar_r : (sar_r & ~bit_r);
	end

	// ready flag; clear input acts without the clock
	always_ff @(posedge clk or negedge reset_n or negedge ready_flag_clear_n)
	begin
		if (!reset_n || !ready_flag_clear_n)
			ready_r <= 1'b0;
		else if (new_period1 && !clr_low)
			ready_r <= 1'b1;
		// drop at later of period 2 and start
		else if (state_r != sac_pkg::SAC_RUN && start_low)
			ready_r <= 1'b0;
		else if (state_r == sac_pkg::SAC_RUN && tick && period_r == `SAC_PER_FIRST
			&& start_low)
			ready_r <= 1'b0;
	end

	// registered outputs
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			track_input <= 1'b1;
			hold_input <= 1'b0;
			trial_code <= `SAC_RESULT_RST;
			result_bus <= '0;
			internal_clock_running <= 1'b1;
		end
		else
		begin
			track_input <= period_r <= `SAC_PER_TRACK_END;
			hold_input <= period_r >= `SAC_PER_MSB;
			trial_code <= sar_r;
			result_bus.data <= result_r;
			result_bus.data_oe[`SAC_UPPER_HI:`SAC_UPPER_LO] <=
				{8{!upper_bits_output_enable_n}};
			result_bus.data_oe[`SAC_LOWER_HI:0] <= {2{!lower_bits_output_enable_n}};
			internal_clock_running <= use_internal_clock && state_r != sac_pkg::SAC_STOPPED;
		end
	end
	assign result_ready_flag = ready_r;
endmodule // sac_ctrl

// ===== sac_sva.sv
// assertions on the sequencer ports
`timescale 1ns/1ps
module sac_sva #(parameter logic [7:0] INT_DIV = 8'h02) (
	input wire logic clk, reset_n, use_internal_clock, ext_conv_clock, conversion_start_n,
	input wire logic ready_flag_clear_n, upper_bits_output_enable_n,
	input wire logic lower_bits_output_enable_n, comparator_high, track_input, hold_input,
	input wire logic [9:0] trial_code,
	input wire sac_pkg::sac_bus_t result_bus,
	input wire logic result_ready_flag, internal_clock_running
);
	logic [7:0] hold_cnt_r;
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			hold_cnt_r <= 8'h00;
		else
			hold_cnt_r <= hold_input ? hold_cnt_r + 8'h01 : 8'h00;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	chk_track_hold_split: assert property (track_input != hold_input)
		else $error("track and hold overlap");
	chk_clear_drops: assert property (!ready_flag_clear_n |-> !result_ready_flag)
		else $error("ready survives clear");
	chk_upper_on: assert property (!upper_bits_output_enable_n [*3] |-> &result_bus.data_oe[9:2])
		else $error("upper bits not driven");
	chk_upper_off: assert property (upper_bits_output_enable_n [*3] |-> !(|result_bus.data_oe[9:2]))
		else $error("upper bits not floated");
	chk_lower_on: assert property (!lower_bits_output_enable_n [*3] |-> &result_bus.data_oe[1:0])
		else $error("lower bits not driven");
	chk_lower_off: assert property (lower_bits_output_enable_n [*3] |-> !(|result_bus.data_oe[1:0]))
		else $error("lower bits not floated");
	chk_data_at_p1: assert property ($changed(result_bus.data) |-> $rose(track_input))
		else $error("result moved outside period 1");
	chk_ready_at_p1: assert property ($rose(result_ready_flag) |=> $rose(track_input))
		else $error("ready rose outside period 1");
	chk_hold_len: assert property ($fell(hold_input) && use_internal_clock |-> hold_cnt_r == 10 * INT_DIV)
		else $error("hold span wrong");
endmodule // sac_sva
bind sac_ctrl sac_sva #(.INT_DIV(INT_DIV)) chk_u (.*);

// ===== sac_host.sv
// comparator and result capture beside the sequencer
`timescale 1ns/1ps
module sac_host (
	input wire logic clk,
	input wire logic [9:0] analog_code, trial_code,
	input wire sac_pkg::sac_bus_t result_bus,
	input wire logic result_ready_flag,
	output logic comparator_high,
	output logic [9:0] captured
);
	logic ready_d_r;
	// a trial at or below the input keeps its bit
	assign comparator_high = trial_code <= analog_code;
	always_ff @(posedge clk)
	begin
		ready_d_r <= result_ready_flag;
		if (ready_d_r && !result_ready_flag)
			captured <= result_bus.data;
	end
endmodule // sac_host

// ===== tb_sac_ctrl.sv
// self-checking bench for the sequencer
`timescale 1ns/1ps
module tb_sac_ctrl;
	logic clk = 1'b0, reset_n = 1'b0, use_internal_clock = 1'b1, ext_conv_clock = 1'b0;
	logic conversion_start_n = 1'b0, ready_flag_clear_n = 1'b1;
	logic upper_bits_output_enable_n = 1'b0, lower_bits_output_enable_n = 1'b0;
	logic comparator_high, track_input, hold_input, result_ready_flag, internal_clock_running;
	logic [9:0] trial_code, analog_code = 10'h000, captured;
	sac_pkg::sac_bus_t result_bus;
	int fail_count = 0, n_tests = 0;
	always #20 clk = ~clk;
	// external period clock, 8 clk per period
	always
	begin
		repeat (4) @(posedge clk);
		#2 ext_conv_clock = ~ext_conv_clock;
	end
	sac_ctrl #(.INT_DIV(8'h02)) dut_u (.*);
	sac_host host_u (.*);
	task automatic chk(input logic [9:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_ready(input logic v, output int n);
		for (n = 0; n < 900 && result_ready_flag !== v; n++)
			#40;
		chk(result_ready_flag, v);
	endtask
	task automatic free_run();
		int a, b;
		logic [9:0] c[3] = '{10'h000, 10'h3ff, 10'h2a5};
		foreach (c[k])
		begin
			analog_code = c[k];
			wait_ready(1, a);
			wait_ready(0, a);
			wait_ready(1, b);
			wait_ready(0, a);
			wait_ready(1, b);
			chk(10'(a), 10'h002);
			chk(10'(a + b), 10'h01a);
			// result bus is one register behind the flag
			#40 chk(result_bus.data, c[k]);
			chk(captured, c[k]);
		end
	endtask
	task automatic clear_test();
		int a;
		wait_ready(1, a);
		ready_flag_clear_n = 1'b0;
		#1 chk(result_ready_flag, 1'b0);
		// released well before the next period 1
		#39 ready_flag_clear_n = 1'b1;
	endtask
	task automatic stall_test();
		int a;
		logic [9:0] d;
		wait_ready(1, a);
		wait_ready(0, a);
		conversion_start_n = 1'b1;
		wait_ready(1, a);
		#400 chk(internal_clock_running, 1'b0);
		chk(track_input, 1'b1);
		d = result_bus.data;
		for (int i = 0; i < 4; i++)
		begin
			{upper_bits_output_enable_n, lower_bits_output_enable_n} = 2'(i);
			#120 chk(result_bus.data_oe, {{8{~i[1]}}, {2{~i[0]}}});
			chk(result_bus.data, d);
		end
		conversion_start_n = 1'b0;
		wait_ready(0, a);
		#200 chk(internal_clock_running, 1'b1);
	endtask
	task automatic ext_test();
		int a;
		use_internal_clock = 1'b0;
		wait_ready(1, a);
		wait_ready(0, a);
		conversion_start_n = 1'b1;
		wait_ready(1, a);
		#2000 chk(track_input, 1'b1);
		chk(result_ready_flag, 1'b1);
		conversion_start_n = 1'b0;
		wait_ready(0, a);
		chk(10'(a < 5), 10'h001);
		#1200 chk(hold_input, 1'b1);
	endtask
	task automatic complete_run();
		if (fail_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		#2 reset_n = 1'b1;
		free_run();
		clear_test();
		stall_test();
		ext_test();
		complete_run();
	end
	initial
	begin
		#2000000;
		fail_count++;
		complete_run();
	end
endmodule // tb_sac_ctrl
